// *** pkg/ubt_pkg.sv ***
// Shared constants and carrier types of the serial transceiver
package ubt_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OFS   = 8'h00;
  localparam logic [7:0] CTRL_OFS  = 8'h04;
  localparam logic [7:0] TXD_OFS   = 8'h08;
  localparam logic [7:0] TXSTA_OFS = 8'h0c;
  localparam logic [7:0] RXD_OFS   = 8'h10;
  localparam logic [7:0] RXSTA_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RST  = 8'h01;
  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int TXSTA_FULL = 0;
  localparam int TXSTA_BUSY = 1;
  localparam int RXSTA_FULL = 0;
  localparam int RXSTA_BUSY = 1;
  localparam int RXSTA_OERR = 2;
  localparam int RXSTA_FERR = 3;
  localparam int RXSTA_PERR = 4;
  localparam int RXSTA_SERR = 5;

  // ----------------------------------------------------------------
  // Bit divisors in prescaled source ticks
  // ----------------------------------------------------------------
  localparam logic [7:0] DIV_RC_115200 = 8'h05;
  localparam logic [7:0] DIV_RC_57600  = 8'h0b;
  localparam logic [7:0] DIV_RC_9600   = 8'h40;
  localparam logic [7:0] DIV_RC_14400  = 8'h80;
  localparam logic [7:0] DIV_XT_2400   = 8'h07;
  localparam logic [7:0] DIV_XT_1200   = 8'h0e;
  localparam logic [7:0] DIV_XT_600    = 8'h1c;
  localparam logic [7:0] DIV_XT_300    = 8'h38;

  // ----------------------------------------------------------------
  // Register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       clock_source_select;
    logic       receive_enable_b;
    logic [2:0] rc_prescaler_code;
    logic       parity_mode_select;
    logic       parity_enable_bit;
    logic       word_length_select;
  } ubt_cmd_s;

  typedef struct packed {
    logic       echo_mode_bit;
    logic       receive_enable_a;
    logic       transmit_enable_bit;
    logic       receive_line_invert;
    logic       transmit_line_invert;
    logic [2:0] baud_rate_code;
  } ubt_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP
  } ubt_state_e;

endpackage

// *** rtl/ubt_uart.sv ***
// Serial transceiver with APB register slave
//
// Function
// - Select bit clear uses RC oscillator
// - Select bit set uses crystal oscillator
// - RC prescaler and rate codes give rates
// - Crystal rate codes give 2400 to 300
// - Crystal rates carry fixed negative error
// - Transmit starts only while transmit enable set
// - Either receive enable bit enables reception
// - Word length selects seven or eight bits
// - Parity appended on send, checked on receive
// - Invert bits invert receive and transmit lines
// - Echo drives receive line xor invert
// - Data write sets holding full flag
// - Idle shifter loads holding word, clears flag
// - Transmit interrupt when holding word loaded
// - Busy high while word shifts out
// - Least significant bit first both ways
// - Start bit sets receiver busy
// - Stop bit stores word, sets full, interrupts
// - Unread overwrite sets overrun, status write clears
// - Start error updated at each transfer
// - Parity error updated at each transfer
// - Missing stop bit sets frame error
`timescale 1ns/1ps

module ubt_uart
  import ubt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rc_osc_in,
  input  wire logic              xtal_osc_in,
  input  wire logic              rx_pin,
  output logic                   tx_pin,
  output logic                   irq_tx,
  output logic                   irq_rx
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 8) begin : g_chk
    $error("ADDR_W must lie between 5 and 8");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] bit_div(input logic xt,
                                         input logic [2:0] code);
    logic [7:0] d;
    d = DIV_RC_9600;
    if (xt) begin
      case (code)
        3'h0:    d = DIV_XT_300;
        3'h1:    d = DIV_XT_600;
        3'h2:    d = DIV_XT_1200;
        default: d = DIV_XT_2400;
      endcase
    end else begin
      case (code)
        3'h7:    d = DIV_RC_115200;
        3'h6:    d = DIV_RC_57600;
        3'h4:    d = DIV_RC_14400;
        default: d = DIV_RC_9600;
      endcase
    end
    return d;
  endfunction

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic wl8,
                                   input logic even);
    logic p;
    p = ^(d & {wl8, 7'h7f});
    return even ? p : ~p;
  endfunction

  // ----------------------------------------------------------------
  // Registers and flags
  // ----------------------------------------------------------------
  ubt_cmd_s   cmd_ff;
  ubt_ctrl_s  ctrl_ff;
  logic [7:0] txd_ff;
  logic [7:0] rxd_ff;
  logic       tx_full_ff;
  logic       rx_full_ff;
  logic       oerr_ff;
  logic       ferr_ff;
  logic       perr_ff;
  logic       serr_ff;
  logic       pready_ff;
  logic       pslverr_ff;
  logic [31:0] prdata_ff;
  logic       irq_tx_ff;
  logic       irq_rx_ff;
  logic       tx_pin_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [7:0] ofs;
  logic       acc;
  logic       done;
  logic       hit;
  logic       wr_done;
  logic       rd_done;

  assign ofs     = 8'(paddr) & 8'hfc;
  assign acc     = psel & penable;
  assign done    = acc & pready_ff;
  assign hit     = (ofs == CMD_OFS) || (ofs == CTRL_OFS) ||
                   (ofs == TXD_OFS) || (ofs == TXSTA_OFS) ||
                   (ofs == RXD_OFS) || (ofs == RXSTA_OFS);
  assign wr_done = done & pwrite & hit;
  assign rd_done = done & ~pwrite & hit;

  // ----------------------------------------------------------------
  // Input synchronisers: rx, rc, xtal
  // ----------------------------------------------------------------
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic [2:0] sync3_ff;
  logic [2:0] filt_ff;
  logic [2:0] filt_prev_ff;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1_ff     <= 3'h1;
      sync2_ff     <= 3'h1;
      sync3_ff     <= 3'h1;
      filt_ff      <= 3'h1;
      filt_prev_ff <= 3'h1;
    end else begin
      sync1_ff     <= {xtal_osc_in, rc_osc_in, rx_pin};
      sync2_ff     <= sync1_ff;
      sync3_ff     <= sync2_ff;
      for (int i = 0; i < 3; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          filt_ff[i] <= sync3_ff[i];
        end
      end
      filt_prev_ff <= filt_ff;
    end
  end

  // ----------------------------------------------------------------
  // Source select and prescaler
  // ----------------------------------------------------------------
  logic       src_tick;
  logic [1:0] pre_cnt_ff;
  logic [1:0] pre_max;
  logic       tick;
  logic [7:0] div;

  assign src_tick = cmd_ff.clock_source_select ?
                    (filt_ff[2] & ~filt_prev_ff[2]) :
                    (filt_ff[1] & ~filt_prev_ff[1]);
  assign pre_max  = (cmd_ff.rc_prescaler_code == 3'h0) ? 2'h0 :
                    (cmd_ff.rc_prescaler_code == 3'h1) ? 2'h1 :
                    2'h3;
  assign tick     = src_tick & (pre_cnt_ff == pre_max);
  assign div      = bit_div(cmd_ff.clock_source_select,
                            ctrl_ff.baud_rate_code);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pre_cnt_ff <= 2'h0;
    end else if (src_tick) begin
      pre_cnt_ff <= (pre_cnt_ff == pre_max) ? 2'h0 : pre_cnt_ff + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  ubt_state_e tx_st_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic       tx_par_ff;
  logic       tx_load;
  logic       tx_end;
  logic       tx_line;
  logic [2:0] nbits;

  assign nbits   = cmd_ff.word_length_select ? 3'h7 : 3'h6;
  assign tx_load = (tx_st_ff == ST_IDLE) & tx_full_ff &
                   ctrl_ff.transmit_enable_bit;
  assign tx_end  = tick & (tx_cnt_ff == div - 8'h1);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_st_ff  <= ST_IDLE;
      tx_sh_ff  <= DATA_RST;
      tx_cnt_ff <= 8'h0;
      tx_bit_ff <= 3'h0;
      tx_par_ff <= 1'b0;
    end else begin
      if (tick) begin
        tx_cnt_ff <= tx_end ? 8'h0 : tx_cnt_ff + 8'h1;
      end
      case (tx_st_ff)
        ST_IDLE: begin
          if (tx_load) begin
            tx_st_ff  <= ST_START;
            tx_sh_ff  <= txd_ff;
            tx_par_ff <= par_bit(txd_ff, cmd_ff.word_length_select,
                                 cmd_ff.parity_mode_select);
            tx_cnt_ff <= 8'h0;
          end
        end
        ST_START: begin
          if (tx_end) begin
            tx_st_ff  <= ST_DATA;
            tx_bit_ff <= 3'h0;
          end
        end
        ST_DATA: begin
          if (tx_end) begin
            tx_sh_ff  <= {1'b0, tx_sh_ff[7:1]};
            tx_bit_ff <= tx_bit_ff + 3'h1;
            if (tx_bit_ff == nbits) begin
              tx_st_ff <= cmd_ff.parity_enable_bit ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (tx_end) begin
            tx_st_ff <= ST_STOP;
          end
        end
        default: begin
          if (tx_end) begin
            tx_st_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    case (tx_st_ff)
      ST_START: tx_line = 1'b0;
      ST_DATA:  tx_line = tx_sh_ff[0];
      ST_PAR:   tx_line = tx_par_ff;
      default:  tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_pin_ff <= 1'b1;
    end else if (ctrl_ff.echo_mode_bit) begin
      tx_pin_ff <= filt_ff[0] ^ ctrl_ff.transmit_line_invert;
    end else begin
      tx_pin_ff <= tx_line ^ ctrl_ff.transmit_line_invert;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  ubt_state_e rx_st_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] rx_cnt_ff;
  logic [2:0] rx_bit_ff;
  logic       rx_serr_ff;
  logic       rx_perr_ff;
  logic       rx_line;
  logic       rx_line_prev;
  logic       rx_en;
  logic       rx_samp;
  logic       rx_done;
  logic [7:0] rx_word;

  assign rx_en        = ctrl_ff.receive_enable_a |
                        cmd_ff.receive_enable_b;
  assign rx_line      = filt_ff[0] ^ ctrl_ff.receive_line_invert;
  assign rx_line_prev = filt_prev_ff[0] ^ ctrl_ff.receive_line_invert;
  assign rx_samp      = tick & (rx_cnt_ff == ((rx_st_ff == ST_START) ?
                        {1'b0, div[7:1]} : div - 8'h1));
  assign rx_done      = (rx_st_ff == ST_STOP) & rx_samp;
  assign rx_word      = cmd_ff.word_length_select ? rx_sh_ff :
                        {1'b0, rx_sh_ff[7:1]};

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rx_en) begin
      rx_st_ff   <= ST_IDLE;
      rx_sh_ff   <= DATA_RST;
      rx_cnt_ff  <= 8'h0;
      rx_bit_ff  <= 3'h0;
      rx_serr_ff <= 1'b0;
      rx_perr_ff <= 1'b0;
    end else begin
      if (tick) begin
        rx_cnt_ff <= rx_samp ? 8'h0 : rx_cnt_ff + 8'h1;
      end
      case (rx_st_ff)
        ST_IDLE: begin
          if (rx_line_prev && !rx_line) begin
            rx_st_ff  <= ST_START;
            rx_cnt_ff <= 8'h0;
          end
        end
        ST_START: begin
          if (rx_samp) begin
            rx_serr_ff <= rx_line;
            rx_bit_ff  <= 3'h0;
            rx_st_ff   <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_samp) begin
            rx_sh_ff  <= {rx_line, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 3'h1;
            if (rx_bit_ff == nbits) begin
              rx_st_ff <= cmd_ff.parity_enable_bit ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR: begin
          if (rx_samp) begin
            rx_perr_ff <= rx_line != par_bit(rx_word,
                          cmd_ff.word_length_select,
                          cmd_ff.parity_mode_select);
            rx_st_ff   <= ST_STOP;
          end
        end
        default: begin
          if (rx_samp) begin
            rx_st_ff   <= ST_IDLE;
            rx_perr_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register writes and flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cmd_ff  <= CMD_RST;
      ctrl_ff <= CTRL_RST;
      txd_ff  <= DATA_RST;
    end else if (wr_done) begin
      if (ofs == CMD_OFS) begin
        cmd_ff <= pwdata[7:0];
      end else if (ofs == CTRL_OFS) begin
        ctrl_ff <= pwdata[7:0];
      end else if (ofs == TXD_OFS) begin
        txd_ff <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tx_full_ff <= 1'b0;
      irq_tx_ff  <= 1'b0;
    end else begin
      irq_tx_ff <= tx_load;
      if (wr_done && ofs == TXD_OFS) begin
        tx_full_ff <= 1'b1;
      end else if (tx_load) begin
        tx_full_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rxd_ff     <= DATA_RST;
      rx_full_ff <= 1'b0;
      oerr_ff    <= 1'b0;
      ferr_ff    <= 1'b0;
      perr_ff    <= 1'b0;
      serr_ff    <= 1'b0;
      irq_rx_ff  <= 1'b0;
    end else begin
      irq_rx_ff <= rx_done;
      if (rx_done) begin
        rxd_ff     <= rx_word;
        rx_full_ff <= 1'b1;
        ferr_ff    <= ~rx_line;
        perr_ff    <= rx_perr_ff;
        serr_ff    <= rx_serr_ff;
      end else if (rd_done && ofs == RXD_OFS) begin
        rx_full_ff <= 1'b0;
      end
      if (rx_done && rx_full_ff && !(rd_done && ofs == RXD_OFS)) begin
        oerr_ff <= 1'b1;
      end else if (wr_done && ofs == RXSTA_OFS) begin
        oerr_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~hit;
      prdata_ff  <= 32'h0;
      if (acc && !pready_ff && !pwrite) begin
        if (ofs == CMD_OFS) begin
          prdata_ff[7:0] <= cmd_ff;
        end else if (ofs == CTRL_OFS) begin
          prdata_ff[7:0] <= ctrl_ff;
        end else if (ofs == TXD_OFS) begin
          prdata_ff[7:0] <= txd_ff;
        end else if (ofs == TXSTA_OFS) begin
          prdata_ff[TXSTA_FULL] <= tx_full_ff;
          prdata_ff[TXSTA_BUSY] <= tx_st_ff != ST_IDLE;
        end else if (ofs == RXD_OFS) begin
          prdata_ff[7:0] <= rxd_ff;
        end else if (ofs == RXSTA_OFS) begin
          prdata_ff[RXSTA_FULL] <= rx_full_ff;
          prdata_ff[RXSTA_BUSY] <= rx_st_ff != ST_IDLE;
          prdata_ff[RXSTA_OERR] <= oerr_ff;
          prdata_ff[RXSTA_FERR] <= ferr_ff;
          prdata_ff[RXSTA_PERR] <= perr_ff;
          prdata_ff[RXSTA_SERR] <= serr_ff;
        end
      end
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_pin  = tx_pin_ff;
  assign irq_tx  = irq_tx_ff;
  assign irq_rx  = irq_rx_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence txd_write_s;
    psel && penable && pready_ff && pwrite && ofs == TXD_OFS;
  endsequence

  tx_full_set_a: assert property (txd_write_s |=> tx_full_ff)
    else $error("holding flag not set by data write");
  tx_irq_load_a: assert property (tx_load |=> irq_tx_ff && tx_st_ff == ST_START)
    else $error("load gave no transmit interrupt");
  tx_gate_en_a: assert property (tx_st_ff == ST_IDLE && !ctrl_ff.transmit_enable_bit |=> tx_st_ff == ST_IDLE)
    else $error("transmit started while disabled");
  tx_start_low_a: assert property (tx_st_ff == ST_START && !ctrl_ff.echo_mode_bit && !ctrl_ff.transmit_line_invert |=> !tx_pin_ff)
    else $error("start bit not low");
  echo_path_a: assert property (ctrl_ff.echo_mode_bit |=> tx_pin_ff == $past(filt_ff[0] ^ ctrl_ff.transmit_line_invert))
    else $error("echo output wrong");
  rx_store_a: assert property (rx_done |=> rx_full_ff && irq_rx_ff && rxd_ff == $past(rx_word))
    else $error("received word not stored");
  rx_overrun_a: assert property (rx_done && rx_full_ff && !rd_done |=> oerr_ff)
    else $error("overrun not flagged");
  rx_disable_a: assert property (!rx_en |=> rx_st_ff == ST_IDLE)
    else $error("receiver active while disabled");
  rx_frame_a: assert property (rx_done && !rx_line |=> ferr_ff)
    else $error("frame error not flagged");
  apb_ready_a: assert property (acc && !pready_ff |=> pready_ff ##1 !pready_ff)
    else $error("apb answer timing wrong");

endmodule

// *** verification/uart_baud_tx_rx_bench.sv ***
// Self-checking bench of the serial transceiver
`timescale 1ns/1ps

module uart_baud_tx_rx_bench;
  import ubt_pkg::*;
  logic        ref_clk;
  logic        sys_rst;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  ph;
  logic        rx_pin;
  logic        tx_pin;
  logic        irq_tx;
  logic        irq_rx;
  logic [15:0] bc;
  logic [3:0]  nb;
  logic        inv;
  logic        hold;
  logic [31:0] q;
  logic        e;
  int          errors;
  int          comparisons;
  int          tx_n;
  int          rx_n;
  int          k;

  ubt_uart dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rc_osc_in(ph[1]), .xtal_osc_in(ph[2]), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .irq_tx(irq_tx), .irq_rx(irq_rx));
  ubt_remote far (.ref_clk(ref_clk), .tx_pin(tx_pin), .bit_cyc(bc),
    .nb(nb), .inv(inv), .hold(hold), .rx_pin(rx_pin));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;
  // RC source period 4 cycles, crystal 8 cycles
  always @(posedge ref_clk) begin
    ph <= ph + 3'h1;
    if (irq_tx === 1'b1) tx_n++;
    if (irq_rx === 1'b1) rx_n++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [7:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    psel <= 1'b1;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 8'h00);
  endtask

  function automatic int cnt(input int s);
    return s == 0 ? tx_n : s == 1 ? rx_n : far.got_q.size();
  endfunction

  task automatic waitc(input int s, input int t);
    int n;
    n = 0;
    while (cnt(s) < t && n < 9000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 9000) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic rxq(input logic [7:0] d, input int n, input int p,
                     input logic s, input int sl);
    far.send(d, n, p, s, sl);
    rd(RXSTA_OFS);
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {inv, hold, ph} = '0;
    bc = 16'd20;
    nb = 4'd9;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(CMD_OFS);
    chk(q, {24'h000000, CMD_RST});
    rd(CTRL_OFS);
    chk(q, {24'h000000, CTRL_RST});
    rd(8'h18);
    chk({e, q[30:0]}, 32'h80000000);
    wr(CMD_OFS, 8'h01);
    wr(CTRL_OFS, 8'h47);
    wr(TXD_OFS, 8'ha5);
    repeat (300) @(posedge ref_clk);
    rd(TXSTA_OFS);
    chk(q, 32'h1);
    chk(far.got_q.size(), 0);
    wr(CTRL_OFS, 8'h67);
    wr(TXD_OFS, 8'h3c);
    rd(TXSTA_OFS);
    chk(q, 32'h3);
    waitc(2, 2);
    chk(far.got_q[0], 10'h1a5);
    chk(far.got_q[1], 10'h13c);
    chk(tx_n, 2);
    repeat (24) @(posedge ref_clk);
    rd(TXSTA_OFS);
    chk(q, 32'h0);
    rxq(8'h5a, 8, -1, 1'b1, 20);
    chk(q, 32'h1);
    rd(RXD_OFS);
    chk(q, 32'h5a);
    rd(RXSTA_OFS);
    chk(q, 32'h0);
    fork
      begin
        far.send(8'h11, 8, -1, 1'b1, 20);
        rxq(8'h22, 8, -1, 1'b1, 20);
      end
      begin
        repeat (60) @(posedge ref_clk);
        rd(RXSTA_OFS);
        chk(q, 32'h2);
      end
    join
    chk(q, 32'h5);
    rd(RXD_OFS);
    chk(q, 32'h22);
    wr(RXSTA_OFS, 8'h00);
    rd(RXSTA_OFS);
    chk(q, 32'h0);
    rxq(8'h33, 8, -1, 1'b0, 20);
    chk(q, 32'h9);
    rd(RXD_OFS);
    rxq(8'hff, 8, -1, 1'b1, 5);
    chk(q, 32'h21);
    rd(RXD_OFS);
    chk(q, 32'hff);
    nb = 4'd10;
    wr(CMD_OFS, 8'h03);
    wr(TXD_OFS, 8'h07);
    waitc(2, 3);
    chk(far.got_q[2], 10'h207);
    rxq(8'h07, 8, 1, 1'b1, 20);
    chk(q, 32'h11);
    rd(RXD_OFS);
    nb = 4'd9;
    wr(CMD_OFS, 8'h06);
    wr(TXD_OFS, 8'h15);
    waitc(2, 4);
    chk(far.got_q[3], 10'h195);
    rxq(8'h15, 7, 1, 1'b1, 20);
    chk(q, 32'h1);
    rd(RXD_OFS);
    chk(q, 32'h15);
    wr(CMD_OFS, 8'h01);
    wr(CTRL_OFS, 8'h27);
    k = rx_n;
    far.send(8'h44, 8, -1, 1'b1, 20);
    chk(rx_n, k);
    wr(CMD_OFS, 8'h41);
    far.send(8'h44, 8, -1, 1'b1, 20);
    rd(RXD_OFS);
    chk(q, 32'h44);
    wr(CMD_OFS, 8'h01);
    wr(CTRL_OFS, 8'h37);
    inv <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wr(CTRL_OFS, 8'h77);
    far.send(8'h96, 8, -1, 1'b1, 20);
    rd(RXD_OFS);
    chk(q, 32'h96);
    wr(CTRL_OFS, 8'h27);
    inv <= 1'b0;
    repeat (8) @(posedge ref_clk);
    bc = 16'd112;
    wr(CMD_OFS, 8'h89);
    wr(CTRL_OFS, 8'h63);
    wr(TXD_OFS, 8'hc3);
    waitc(2, 5);
    chk(far.got_q[4], 10'h1c3);
    far.send(8'h3a, 8, -1, 1'b1, 112);
    rd(RXD_OFS);
    chk(q, 32'h3a);
    wr(CTRL_OFS, 8'h8b);
    repeat (8) @(posedge ref_clk);
    chk(tx_pin, 1'b0);
    hold <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(tx_pin, 1'b1);
    wrap_up();
  end
endmodule

// *** verification/ubt_remote.sv ***
// Remote serial transceiver model facing the receive and transmit lines
`timescale 1ns/1ps

module ubt_remote (
  input  wire logic        ref_clk,
  input  wire logic        tx_pin,
  input  wire logic [15:0] bit_cyc,
  input  wire logic [3:0]  nb,
  input  wire logic        inv,
  input  wire logic        hold,
  output logic             rx_pin
);
  logic       line;
  logic [9:0] sh;
  logic [9:0] got_q[$];

  // Idle high, forced low or inverted on request
  assign rx_pin = (hold ? 1'b0 : line) ^ inv;
  initial line = 1'b1;

  // ----------------------------------------------------------------
  // Frame sender
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] d, input int n, input int p,
                      input logic s, input int sl);
    line <= 1'b0;
    repeat (sl) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      line <= d[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    if (p >= 0) begin
      line <= p[0];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    line <= s;
    repeat (bit_cyc) @(posedge ref_clk);
    line <= 1'b1;
    repeat (bit_cyc) @(posedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // Frame catcher, mid-bit sampling, bits in line order
  // ----------------------------------------------------------------
  initial forever begin
    @(negedge tx_pin);
    sh = '0;
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      sh[i] = tx_pin;
    end
    got_q.push_back(sh);
  end
endmodule
